// file: src/buck_regs_pkg.sv
package buck_regs_pkg;

	// register byte addresses (each offset is four times its word index)
	localparam logic [7:0] sleep_voltage_setpoint_idx = 8'h22;
	localparam logic [7:0] switching_mode_select_idx = 8'h23;
	localparam logic [7:0] regulator_config_idx = 8'h24;
	localparam logic [11:0] sleep_voltage_setpoint_addr = 12'h088;
	localparam logic [11:0] switching_mode_select_addr = 12'h08C;
	localparam logic [11:0] regulator_config_addr = 12'h090;

	// reset values
	localparam logic [5:0] sleep_setpoint_rst = 6'h00;
	localparam logic [7:0] mode_reg_printed_rst = 8'h80;
	localparam logic [3:0] switching_mode_rst = mode_reg_printed_rst[3:0];
	localparam logic sleep_state_rst = 1'b0;
	localparam logic [7:0] regulator_config_rst = 8'h00;

	// field positions
	localparam int sleep_setpoint_lsb = 0;
	localparam int switching_mode_lsb = 0;
	localparam int sleep_state_bit = 5;
	localparam int current_limit_bit = 0;
	localparam int switch_freq_lsb = 2;
	localparam int phase_clock_lsb = 4;
	localparam int dvs_ramp_lsb = 6;

	// set point scale, in millivolts
	localparam int setpoint_base_mv = 300;
	localparam int setpoint_step_mv = 25;
	localparam int setpoint_max_mv = 1875;

	typedef struct packed {
		logic [1:0] dvs_ramp_speed_sel;
		logic [1:0] phase_clock_sel;
		logic [1:0] switch_freq_sel;
		logic spare_bit;
		logic current_limit_low_sel;
	} regulator_config_t;

	typedef struct packed {
		logic [5:0] sleep_setpoint_code;
		logic [10:0] sleep_voltage_mv;
		logic [3:0] switching_mode_code;
		logic sleep_state_select;
		regulator_config_t cfg;
	} regulator_ctrl_t;

endpackage

// file: src/buck_sleep_mode_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: sleep set point six bits, resets zero
// R2: set point code maps 300 mV plus 25 mV steps
// R3: four-bit switching mode selector in bits 3:0
// R4: mode bit5 selects sleep off or PFM
// R5: config bit0 selects high or low current limit
// R6: config bits 3:2 switching frequency select
// R7: config bits 5:4 phase clock select
// R8: config bits 7:6 DVS ramp speed select
// R9: unused sleep and mode bits read zero
//
module buck_sleep_mode_config_regs
	import buck_regs_pkg::*;
(
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// regulator controls
	output regulator_ctrl_t ctrl
);

	////////////////////////////////////////////////////////////////////
	logic [5:0] sleep_r, sleep_nxt;
	logic [3:0] mode_r, mode_nxt;
	logic sstate_r, sstate_nxt;
	regulator_config_t cfg_r, cfg_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	logic access, wr_ok, hit;

	// single access phase, stretched while clk_en is low; pready is combinational
	assign access = psel & penable & clk_en;
	assign wr_ok = access & pwrite & pstrb[0];
	assign pready = psel & penable & clk_en;
	assign prdata = rdata_r;
	assign pslverr = err_r;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		sleep_nxt = sleep_r;
		mode_nxt = mode_r;
		sstate_nxt = sstate_r;
		cfg_nxt = cfg_r;
		rdata_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		hit = 1'b1;
		if (paddr == sleep_voltage_setpoint_addr) begin
			if (wr_ok)
				sleep_nxt = pwdata[sleep_setpoint_lsb +: 6]; // R1
			rdata_nxt[sleep_setpoint_lsb +: 6] = sleep_r; // R9
		end else if (paddr == switching_mode_select_addr) begin
			if (wr_ok) begin
				mode_nxt = pwdata[switching_mode_lsb +: 4]; // R3
				sstate_nxt = pwdata[sleep_state_bit]; // R4
			end
			rdata_nxt[switching_mode_lsb +: 4] = mode_r; // R9
			rdata_nxt[sleep_state_bit] = sstate_r; // R9
		end else if (paddr == regulator_config_addr) begin
			if (wr_ok)
				cfg_nxt = pwdata[7:0]; // R5 R6 R7 R8
			rdata_nxt[7:0] = cfg_r;
		end else begin
			hit = 1'b0;
		end
		// unmapped addresses answer with an error, writes dropped
		if (access && !hit)
			err_nxt = 1'b1;
		if (!access) begin
			rdata_nxt = rdata_r;
			err_nxt = err_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_r <= sleep_setpoint_rst; // R1
			mode_r <= switching_mode_rst; // R3
			sstate_r <= sleep_state_rst; // R4
			cfg_r <= regulator_config_rst;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else if (clk_en) begin
			sleep_r <= sleep_nxt;
			mode_r <= mode_nxt;
			sstate_r <= sstate_nxt;
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered millivolt view of the sleep set point, for analog trim
	logic [10:0] mv_r, mv_nxt;
	always_comb begin
		mv_nxt = 11'(setpoint_base_mv) + 11'(sleep_r) * 11'(setpoint_step_mv); // R2
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mv_r <= 11'(setpoint_base_mv);
		else if (clk_en)
			mv_r <= mv_nxt;
	end

	always_comb begin
		ctrl.sleep_setpoint_code = sleep_r;
		ctrl.sleep_voltage_mv = mv_r; // R2
		ctrl.switching_mode_code = mode_r;
		ctrl.sleep_state_select = sstate_r; // R4
		ctrl.cfg = cfg_r; // R5 R6 R7 R8
	end

endmodule
`default_nettype wire

// file: dv/buck_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module buck_regs_monitor
	import buck_regs_pkg::*;
(
	// bus and controls
	input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0] pstrb,
	input wire regulator_ctrl_t ctrl
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel & penable & clk_en;
	wire wr = acc & pwrite & pstrb[0];
	wire rd = acc & ~pwrite;
	wire w0 = wr & (paddr == 12'h088);
	wire w1 = wr & (paddr == 12'h08c);
	wire w2 = wr & (paddr == 12'h090);
	chk_sleep_write: assert property (
		w0 |=> ctrl.sleep_setpoint_code == $past(pwdata[5:0])) else $error("sleep code");
	chk_volt_map: assert property (
		clk_en |=> ctrl.sleep_voltage_mv == 11'd300 + 11'd25 * $past(ctrl.sleep_setpoint_code))
		else $error("sleep mv");
	chk_mode_write: assert property (
		w1 |=> ctrl.switching_mode_code == $past(pwdata[3:0])) else $error("mode code");
	chk_sleep_state: assert property (
		w1 |=> ctrl.sleep_state_select == $past(pwdata[5])) else $error("sleep state");
	chk_cfg_write: assert property (
		w2 |=> ctrl.cfg == $past(pwdata[7:0])) else $error("cfg write");
	chk_cfg_hold: assert property (
		!w2 |=> $stable(ctrl.cfg)) else $error("cfg hold");
	chk_sleep_read: assert property (
		rd && paddr == 12'h088 |=> prdata == {26'h0, ctrl.sleep_setpoint_code})
		else $error("sleep read");
	chk_mode_read: assert property (
		rd && paddr == 12'h08c |=> prdata == {26'h0, ctrl.sleep_state_select, 1'b0,
		ctrl.switching_mode_code}) else $error("mode read");
	cover property (w2);
	cover property (psel && penable && !clk_en);
	cover property (rd && paddr == 12'h0a0);
endmodule
bind buck_sleep_mode_config_regs buck_regs_monitor mon (.*);
`default_nettype wire

// file: dv/buck_sleep_mode_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module buck_sleep_mode_config_regs_bench;
	import buck_regs_pkg::*;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, rd = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, seed = 32'h190a_0e2b;
	logic [3:0] pstrb = 4'hf;
	logic [32:0] q[$];
	regulator_ctrl_t ctrl;
	int err_count = 0, checks_done = 0, cyc = 0;
	buck_sleep_mode_config_regs dut (.*);
	always #10 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(logic [32:0] s, logic [32:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// request held until pready seen high at an edge
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w) q.push_back(e);
		// release after the completing edge; a held request would repeat the access
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	// read data is registered, so compare one edge after completion
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 6000) begin
			err_count++;
			give_verdict();
		end
		clk_en <= (xs() & 3) != 0;
		rd <= psel & penable & pready & ~pwrite;
		if (rd) chk({pslverr, prdata}, q.pop_front());
	end
	initial begin
		logic [31:0] d;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h088, 0, 0);
		apb(0, 12'h08c, 0, {29'h0, switching_mode_rst});
		apb(0, 12'h090, 0, 0);
		$display("reset values done");
		repeat (40) begin
			d = xs();
			apb(1, 12'h088, d, 0);
			apb(1, 12'h08c, d, 0);
			apb(1, 12'h090, d, 0);
			apb(0, 12'h088, 0, {27'h0, d[5:0]});
			apb(0, 12'h08c, 0, {27'h0, d[5], 1'b0, d[3:0]});
			apb(0, 12'h090, 0, {25'h0, d[7:0]});
		end
		$display("random access done");
		apb(1, 12'h0a0, d, 0);
		apb(0, 12'h0a0, 0, 33'h1_0000_0000);
		pstrb <= 4'he;
		apb(1, 12'h090, ~d, 0);
		pstrb <= 4'hf;
		apb(0, 12'h090, 0, {25'h0, d[7:0]});
		repeat (3) @(posedge pclk);
		$display("refusal cases done");
		give_verdict();
	end
endmodule
`default_nettype wire
